// file: logic/sgp_ports.sv
// Contract
// - Port 6 pull-up on only when direction is 0 and enable is 1.
// - All port 6 pull-ups off after reset.
// - Port 7 data latch is 8-bit read/write, reset to 0x00.
// - Port 7 output bit reads back the latched value.
// - Port 7 input bit reads back the pin level.
// - Port 7 direction 1 drives pin from latch, 0 makes input.
// - Port 7 direction register is write-only and reads all ones.
// - Port 7 direction resets to 0x00, all pins inputs.
// - Field 00xx gives port 7 gpio, else pin n is segment n+17.
// - Port 7 settings act only while pins are general I/O.
// - Port 7 pins high-z in reset and standby, hold in sleep modes.
// - Port 8 read gives latch when direction 1, pin when 0.
// - Port 8 data latch is 8-bit read/write, reset to 0x00.
// - Port 8 direction 1 makes output, 0 makes input.
// - Port 8 direction register is write-only and reads all ones.
// - Port 8 direction resets to 0x00, all pins inputs.
// - Port 8 settings act only while pins are general I/O.
// - Field 000x gives port 8 gpio, else pin n is segment n+25.
// - Port 8 pins high-z in reset and standby, hold in sleep modes.
`timescale 1ns/100ps
module sgp_ports #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input  wire logic                         clk_sys,
   input  wire logic                         rst_n,
   // Register bus
   input  wire logic [sgp_pkg::ADDR_W-1:0]   reg_addr,
   input  wire logic [sgp_pkg::DATA_W-1:0]   reg_wdata,
   input  wire logic                         reg_wr,
   input  wire logic                         reg_rd,
   output logic [sgp_pkg::DATA_W-1:0]        reg_rdata_ff,
   output logic                              reg_rvalid_ff,
   // Operating mode
   input  wire sgp_pkg::sgp_pwr_mode_t       pwr_mode,
   // Segment driver values
   input  wire logic [WIDTH-1:0]             p7_lcd_segment_output,
   input  wire logic [WIDTH-1:0]             p8_lcd_segment_output,
   // Port 6 pull-up control
   output logic [WIDTH-1:0]                  p6_pullup_on_ff,
   // Port 7 pins
   input  wire logic [WIDTH-1:0]             p7_pin_in,
   output logic [WIDTH-1:0]                  p7_pin_out_ff,
   output logic [WIDTH-1:0]                  p7_pin_oe_n_ff,
   // Port 8 pins
   input  wire logic [WIDTH-1:0]             p8_pin_in,
   output logic [WIDTH-1:0]                  p8_pin_out_ff,
   output logic [WIDTH-1:0]                  p8_pin_oe_n_ff
);

   if (WIDTH != sgp_pkg::DATA_W) begin
      $error("sgp_ports: WIDTH must equal the bus data width");
   end

   sgp_pkg::sgp_bus_req_t              req;
   logic [WIDTH-1:0]                   port6_direction_ff;
   logic [WIDTH-1:0]                   port6_pullup_enable_ff;
   logic [WIDTH-1:0]                   port7_data_latch_ff;
   logic [WIDTH-1:0]                   port8_data_latch_ff;
   logic [WIDTH-1:0]                   port7_direction_ff;
   logic [WIDTH-1:0]                   port8_direction_ff;
   logic [sgp_pkg::DATA_W-1:0]         lcd_port_control_ff;
   logic [sgp_pkg::SEL_W-1:0]          segment_select_field;
   logic                               p7_gpio;
   logic                               p8_gpio;
   logic [WIDTH-1:0]                   p7_read;
   logic [WIDTH-1:0]                   p8_read;
   logic [sgp_pkg::DATA_W-1:0]         nxt_rdata;
   logic [WIDTH-1:0]                   nxt_pullup;
   sgp_pkg::sgp_pin_drv_t              p7_drv;
   sgp_pkg::sgp_pin_drv_t              p8_drv;

   assign req.addr  = reg_addr;
   assign req.wdata = reg_wdata;
   assign req.wr    = reg_wr;
   assign req.rd    = reg_rd;

   function automatic logic wr_hit(input sgp_pkg::sgp_bus_req_t r,
                                   input logic [sgp_pkg::ADDR_W-1:0] a);
      return r.wr && (r.addr == a);
   endfunction

   // Segment select decode
   assign segment_select_field =
      lcd_port_control_ff[sgp_pkg::SEL_LSB +: sgp_pkg::SEL_W];
   assign p7_gpio = sgp_pkg::is_gpio(segment_select_field, sgp_pkg::PORT_7);
   assign p8_gpio = sgp_pkg::is_gpio(segment_select_field, sgp_pkg::PORT_8);

   // Port 6 registers
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         port6_direction_ff     <= sgp_pkg::RST_BYTE;
         port6_pullup_enable_ff <= sgp_pkg::RST_BYTE;
      end else begin
         if (wr_hit(req, sgp_pkg::ADDR_P6_DIR)) begin
            port6_direction_ff <= req.wdata;
         end
         if (wr_hit(req, sgp_pkg::ADDR_P6_PULLUP)) begin
            port6_pullup_enable_ff <= req.wdata;
         end
      end
   end

   assign nxt_pullup = ~port6_direction_ff & port6_pullup_enable_ff;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         p6_pullup_on_ff <= '0;
      end else begin
         p6_pullup_on_ff <= nxt_pullup;
      end
   end

   // Data latches
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         port7_data_latch_ff <= sgp_pkg::RST_BYTE;
         port8_data_latch_ff <= sgp_pkg::RST_BYTE;
      end else begin
         if (wr_hit(req, sgp_pkg::ADDR_P7_DATA)) begin
            port7_data_latch_ff <= req.wdata;
         end
         if (wr_hit(req, sgp_pkg::ADDR_P8_DATA)) begin
            port8_data_latch_ff <= req.wdata;
         end
      end
   end

   // Direction registers
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         port7_direction_ff <= sgp_pkg::RST_BYTE;
         port8_direction_ff <= sgp_pkg::RST_BYTE;
      end else begin
         if (wr_hit(req, sgp_pkg::ADDR_P7_DIR)) begin
            port7_direction_ff <= req.wdata;
         end
         if (wr_hit(req, sgp_pkg::ADDR_P8_DIR)) begin
            port8_direction_ff <= req.wdata;
         end
      end
   end

   // Lcd port control register
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         lcd_port_control_ff <= sgp_pkg::RST_BYTE;
      end else if (wr_hit(req, sgp_pkg::ADDR_LCD_CTL)) begin
         lcd_port_control_ff <= req.wdata;
      end
   end

   assign p7_read = (port7_direction_ff & port7_data_latch_ff)
                  | (~port7_direction_ff & p7_pin_in);
   assign p8_read = (port8_direction_ff & port8_data_latch_ff)
                  | (~port8_direction_ff & p8_pin_in);

   // Read decode
   always_comb begin
      nxt_rdata = sgp_pkg::UNMAP_READ;
      case (req.addr)
         sgp_pkg::ADDR_P7_DATA:   nxt_rdata = p7_read;
         sgp_pkg::ADDR_P8_DATA:   nxt_rdata = p8_read;
         sgp_pkg::ADDR_P7_DIR:    nxt_rdata = sgp_pkg::WO_READ;
         sgp_pkg::ADDR_P8_DIR:    nxt_rdata = sgp_pkg::WO_READ;
         sgp_pkg::ADDR_P6_DIR:    nxt_rdata = sgp_pkg::WO_READ;
         sgp_pkg::ADDR_P6_PULLUP: nxt_rdata = port6_pullup_enable_ff;
         sgp_pkg::ADDR_LCD_CTL:   nxt_rdata = lcd_port_control_ff;
         default:                 nxt_rdata = sgp_pkg::UNMAP_READ;
      endcase
   end

   // Read data for one cycle
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata_ff  <= sgp_pkg::RST_BYTE;
         reg_rvalid_ff <= 1'b0;
      end else begin
         reg_rvalid_ff <= req.rd;
         if (req.rd) begin
            reg_rdata_ff <= nxt_rdata;
         end else begin
            reg_rdata_ff <= sgp_pkg::RST_BYTE;
         end
      end
   end

   sgp_pin_cell #(
      .WIDTH (WIDTH)
   ) u_p7 (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .data     (port7_data_latch_ff),
      .dir      (port7_direction_ff),
      .gpio_sel (p7_gpio),
      .segment_val (p7_lcd_segment_output),
      .mode     (pwr_mode),
      .out_ff   (p7_drv.out),
      .oe_n_ff  (p7_drv.oe_n)
   );

   sgp_pin_cell #(
      .WIDTH (WIDTH)
   ) u_p8 (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .data     (port8_data_latch_ff),
      .dir      (port8_direction_ff),
      .gpio_sel (p8_gpio),
      .segment_val (p8_lcd_segment_output),
      .mode     (pwr_mode),
      .out_ff   (p8_drv.out),
      .oe_n_ff  (p8_drv.oe_n)
   );

   assign p7_pin_out_ff  = p7_drv.out;
   assign p7_pin_oe_n_ff = p7_drv.oe_n;
   assign p8_pin_out_ff  = p8_drv.out;
   assign p8_pin_oe_n_ff = p8_drv.oe_n;

endmodule

// file: logic/sgp_pkg.sv
package sgp_pkg;

   // Bus and port widths
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int SEL_W  = 4;

   // Register byte addresses
   localparam logic [ADDR_W-1:0] ADDR_P6_PULLUP = 16'hffe3;
   localparam logic [ADDR_W-1:0] ADDR_P6_DIR    = 16'hffe9;
   localparam logic [ADDR_W-1:0] ADDR_P7_DATA   = 16'hffda;
   localparam logic [ADDR_W-1:0] ADDR_P8_DATA   = 16'hffdb;
   localparam logic [ADDR_W-1:0] ADDR_P7_DIR    = 16'hffea;
   localparam logic [ADDR_W-1:0] ADDR_P8_DIR    = 16'hffeb;
   localparam logic [ADDR_W-1:0] ADDR_LCD_CTL   = 16'hffc0;

   // Reset and fixed read values
   localparam logic [DATA_W-1:0] RST_BYTE    = 8'h00;
   localparam logic [DATA_W-1:0] WO_READ     = 8'hff;
   localparam logic [DATA_W-1:0] UNMAP_READ  = 8'h00;

   // Segment select field position inside the lcd port control byte
   localparam int SEL_LSB = 0;

   // Port identifiers for the segment decode
   localparam logic PORT_7 = 1'b0;
   localparam logic PORT_8 = 1'b1;

   // Segment numbers of pin 0 of each port
   localparam int SEGMENT_BASE_P7 = 17;
   localparam int SEGMENT_BASE_P8 = 25;

   // Operating modes, one-hot
   typedef enum logic [5:0] {
      PWR_ACTIVE    = 6'b00_0001,
      PWR_SUBACTIVE = 6'b00_0010,
      PWR_SLEEP     = 6'b00_0100,
      PWR_SUBSLEEP  = 6'b00_1000,
      PWR_WATCH     = 6'b01_0000,
      PWR_STANDBY   = 6'b10_0000
   } sgp_pwr_mode_t;

   // Register bus request
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } sgp_bus_req_t;

   // Drive of one 8-bit pin group
   typedef struct packed {
      logic [DATA_W-1:0] out;
      logic [DATA_W-1:0] oe_n;
   } sgp_pin_drv_t;

   // True when the field hands the given port to general I/O
   function automatic logic is_gpio(input logic [SEL_W-1:0] sel, input logic port);
      logic r;
      r = 1'b0;
      if (port == PORT_7) begin
         r = (sel[3:2] == 2'b00);
      end else begin
         r = (sel[3:1] == 3'b000);
      end
      return r;
   endfunction

endpackage

// file: logic/sgp_pin_cell.sv
`timescale 1ns/100ps
module sgp_pin_cell #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input  wire logic                  clk_sys,
   input  wire logic                  rst_n,
   // Settings
   input  wire logic [WIDTH-1:0]      data,
   input  wire logic [WIDTH-1:0]      dir,
   input  wire logic                  gpio_sel,
   input  wire logic [WIDTH-1:0]      segment_val,
   input  wire sgp_pkg::sgp_pwr_mode_t mode,
   // Pin drive
   output logic [WIDTH-1:0]           out_ff,
   output logic [WIDTH-1:0]           oe_n_ff
);

   if (WIDTH < 1) begin
      $error("sgp_pin_cell: WIDTH must be at least 1");
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         out_ff  <= '0;
         oe_n_ff <= '1;
      end else begin
         case (mode)
            sgp_pkg::PWR_ACTIVE, sgp_pkg::PWR_SUBACTIVE: begin
               if (gpio_sel) begin
                  out_ff  <= data;
                  oe_n_ff <= ~dir;
               end else begin
                  out_ff  <= segment_val;
                  oe_n_ff <= '0;
               end
            end
            sgp_pkg::PWR_STANDBY: begin
               oe_n_ff <= '1;
            end
            sgp_pkg::PWR_SLEEP, sgp_pkg::PWR_SUBSLEEP, sgp_pkg::PWR_WATCH: begin
               out_ff  <= out_ff;
               oe_n_ff <= oe_n_ff;
            end
            default: begin
               out_ff  <= out_ff;
               oe_n_ff <= oe_n_ff;
            end
         endcase
      end
   end

endmodule

// file: tb/sgp_pin_model.sv
`timescale 1ns/100ps
module sgp_pin_model #(
   parameter int WIDTH = 8
) (
   // Drive from the port
   input  wire logic [WIDTH-1:0] out,
   input  wire logic [WIDTH-1:0] oe_n,
   // Level set by the outside device
   input  wire logic [WIDTH-1:0] ext,
   // Level seen at the pin
   output logic      [WIDTH-1:0] pin_in
);
   // Driven bits show the port, released bits the outside level
   assign pin_in = (out & ~oe_n) | (ext & oe_n);
endmodule

// file: tb/sgp_ports_monitor.sv
`timescale 1ns/100ps
module sgp_ports_monitor #(
   parameter int WIDTH = 8
) (
   // Clock, reset and bus
   input wire logic                   clk_sys,
   input wire logic                   rst_n,
   input wire logic [15:0]            reg_addr,
   input wire logic [7:0]             reg_wdata,
   input wire logic                   reg_wr,
   input wire logic                   reg_rd,
   input wire logic [7:0]             reg_rdata_ff,
   input wire logic                   reg_rvalid_ff,
   // Mode and segments
   input wire sgp_pkg::sgp_pwr_mode_t pwr_mode,
   input wire logic [WIDTH-1:0]       p7_lcd_segment_output,
   input wire logic [WIDTH-1:0]       p8_lcd_segment_output,
   // Pins
   input wire logic [WIDTH-1:0]       p6_pullup_on_ff,
   input wire logic [WIDTH-1:0]       p7_pin_in,
   input wire logic [WIDTH-1:0]       p7_pin_out_ff,
   input wire logic [WIDTH-1:0]       p7_pin_oe_n_ff,
   input wire logic [WIDTH-1:0]       p8_pin_in,
   input wire logic [WIDTH-1:0]       p8_pin_out_ff,
   input wire logic [WIDTH-1:0]       p8_pin_oe_n_ff
);
   logic [7:0] d6_ff, u6_ff, d7_ff, d8_ff, l7_ff, l8_ff, lc_ff;
   logic       g7;
   logic       g8;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // Shadow of written registers
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         {d6_ff, u6_ff, d7_ff, d8_ff, l7_ff, l8_ff, lc_ff} <= '0;
      end else if (reg_wr) begin
         case (reg_addr)
            sgp_pkg::ADDR_P6_DIR:    d6_ff <= reg_wdata;
            sgp_pkg::ADDR_P6_PULLUP: u6_ff <= reg_wdata;
            sgp_pkg::ADDR_P7_DIR:    d7_ff <= reg_wdata;
            sgp_pkg::ADDR_P8_DIR:    d8_ff <= reg_wdata;
            sgp_pkg::ADDR_P7_DATA:   l7_ff <= reg_wdata;
            sgp_pkg::ADDR_P8_DATA:   l8_ff <= reg_wdata;
            sgp_pkg::ADDR_LCD_CTL:   lc_ff <= reg_wdata;
            default:                 lc_ff <= lc_ff;
         endcase
      end
   end
   assign g7 = (lc_ff[3:2] == 2'h0);
   assign g8 = (lc_ff[3:1] == 3'h0);
   chk_dir_all_ones: assert property (reg_rd && (reg_addr == sgp_pkg::ADDR_P7_DIR
      || reg_addr == sgp_pkg::ADDR_P8_DIR) |=> reg_rvalid_ff && reg_rdata_ff == 8'hff)
      else $error("direction read not all ones");
   chk_p7_read_mix: assert property (reg_rd && reg_addr == sgp_pkg::ADDR_P7_DATA |=>
      reg_rdata_ff == (($past(d7_ff) & $past(l7_ff)) | (~$past(d7_ff) & $past(p7_pin_in))))
      else $error("port 7 read value wrong");
   chk_p8_read_mix: assert property (reg_rd && reg_addr == sgp_pkg::ADDR_P8_DATA |=>
      reg_rdata_ff == (($past(d8_ff) & $past(l8_ff)) | (~$past(d8_ff) & $past(p8_pin_in))))
      else $error("port 8 read value wrong");
   chk_pullup_gate: assert property (p6_pullup_on_ff == $past(~d6_ff & u6_ff))
      else $error("pull-up state wrong");
   chk_p7_pin_drive: assert property (pwr_mode inside {sgp_pkg::PWR_ACTIVE,
      sgp_pkg::PWR_SUBACTIVE} |=> p7_pin_oe_n_ff == ($past(g7) ? ~$past(d7_ff) : 8'h00)
      && (p7_pin_out_ff & ~p7_pin_oe_n_ff) == (($past(g7) ? $past(l7_ff)
      : $past(p7_lcd_segment_output)) & ~p7_pin_oe_n_ff))
      else $error("port 7 pin drive wrong");
   chk_p8_pin_drive: assert property (pwr_mode inside {sgp_pkg::PWR_ACTIVE,
      sgp_pkg::PWR_SUBACTIVE} |=> p8_pin_oe_n_ff == ($past(g8) ? ~$past(d8_ff) : 8'h00)
      && (p8_pin_out_ff & ~p8_pin_oe_n_ff) == (($past(g8) ? $past(l8_ff)
      : $past(p8_lcd_segment_output)) & ~p8_pin_oe_n_ff))
      else $error("port 8 pin drive wrong");
   chk_standby_hiz: assert property (pwr_mode == sgp_pkg::PWR_STANDBY |=>
      (p7_pin_oe_n_ff & p8_pin_oe_n_ff) == 8'hff) else $error("standby pins driven");
   chk_sleep_hold: assert property (pwr_mode inside {sgp_pkg::PWR_SLEEP,
      sgp_pkg::PWR_SUBSLEEP, sgp_pkg::PWR_WATCH} |=> $stable(p7_pin_out_ff)
      && $stable(p7_pin_oe_n_ff) && $stable(p8_pin_out_ff) && $stable(p8_pin_oe_n_ff))
      else $error("pins moved while held");
   cov_p7_read: cover property (reg_rd && reg_addr == sgp_pkg::ADDR_P7_DATA);
   cov_standby: cover property (pwr_mode == sgp_pkg::PWR_STANDBY);
   cov_all_segment: cover property (!g7 && !g8);
endmodule
bind sgp_ports sgp_ports_monitor #(.WIDTH(WIDTH)) chk_u (
   .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
   .reg_rvalid_ff(reg_rvalid_ff), .pwr_mode(pwr_mode),
   .p7_lcd_segment_output(p7_lcd_segment_output),
   .p8_lcd_segment_output(p8_lcd_segment_output), .p6_pullup_on_ff(p6_pullup_on_ff),
   .p7_pin_in(p7_pin_in), .p7_pin_out_ff(p7_pin_out_ff), .p7_pin_oe_n_ff(p7_pin_oe_n_ff),
   .p8_pin_in(p8_pin_in), .p8_pin_out_ff(p8_pin_out_ff), .p8_pin_oe_n_ff(p8_pin_oe_n_ff));

// file: tb/segment_shared_gpio_ports_bench.sv
`timescale 1ns/100ps
module segment_shared_gpio_ports_bench;
   logic                   clk_sys, rst_n, reg_wr, reg_rd, rvalid;
   logic [15:0]            reg_addr;
   logic [7:0]             reg_wdata, rdata, pu6, s7, s8, e7, e8;
   logic [7:0]             i7, o7, n7, i8, o8, n8;
   sgp_pkg::sgp_pwr_mode_t pwr_mode;
   int                     failures, tests_run, cyc;
   sgp_ports #(.WIDTH(8)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(rdata),
      .reg_rvalid_ff(rvalid), .pwr_mode(pwr_mode), .p7_lcd_segment_output(s7),
      .p8_lcd_segment_output(s8), .p6_pullup_on_ff(pu6), .p7_pin_in(i7),
      .p7_pin_out_ff(o7), .p7_pin_oe_n_ff(n7), .p8_pin_in(i8), .p8_pin_out_ff(o8),
      .p8_pin_oe_n_ff(n8));
   sgp_pin_model m7_u (.out(o7), .oe_n(n7), .ext(e7), .pin_in(i7));
   sgp_pin_model m8_u (.out(o8), .oe_n(n8), .ext(e8), .pin_in(i8));
   initial begin
      clk_sys = 1'h0;
      forever #5 clk_sys = ~clk_sys;
   end
   task automatic give_verdict();
      $display("compares %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 5000) begin
         failures++;
         give_verdict();
      end
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'h0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'h0;
      #1;
      check(rdata, exp);
   endtask
   task automatic settle();
      repeat (2) @(posedge clk_sys);
      #1;
   endtask
   task automatic gpio_case(input bit p);
      logic [15:0] da, ca;
      logic [7:0]  ex;
      da = p ? sgp_pkg::ADDR_P8_DATA : sgp_pkg::ADDR_P7_DATA;
      ca = p ? sgp_pkg::ADDR_P8_DIR : sgp_pkg::ADDR_P7_DIR;
      ex = p ? e8 : e7;
      wr(da, 8'h3c);
      rd(da, ex);
      wr(ca, 8'h0f);
      settle();
      check(p ? n8 : n7, 8'hf0);
      check((p ? o8 : o7) & 8'h0f, 8'h0c);
      rd(da, 8'h0c | (ex & 8'hf0));
      rd(ca, 8'hff);
      $display("test gpio port %0d done", p ? 8 : 7);
   endtask
   initial begin
      sgp_pkg::sgp_pwr_mode_t ms[3];
      logic [7:0] pt[4][3];
      ms = '{sgp_pkg::PWR_SLEEP, sgp_pkg::PWR_SUBSLEEP, sgp_pkg::PWR_WATCH};
      pt = '{'{8'h00, 8'hff, 8'hff}, '{8'hf0, 8'hff, 8'h0f}, '{8'hff, 8'hff, 8'h00},
             '{8'h00, 8'h00, 8'h00}};
      {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      {failures, tests_run, cyc} = '0;
      pwr_mode = sgp_pkg::PWR_ACTIVE;
      {s7, s8, e7, e8} = {8'h5a, 8'hc3, 8'ha5, 8'h96};
      repeat (20) @(posedge clk_sys);
      #1;
      check(n7 & n8, 8'hff);
      check(pu6, 8'h00);
      @(posedge clk_sys);
      rst_n <= 1'h1;
      rd(sgp_pkg::ADDR_P7_DATA, 8'ha5);
      rd(sgp_pkg::ADDR_P8_DATA, 8'h96);
      rd(sgp_pkg::ADDR_P7_DIR, 8'hff);
      rd(sgp_pkg::ADDR_P8_DIR, 8'hff);
      rd(16'h0000, 8'h00);
      wr(sgp_pkg::ADDR_P7_DIR, 8'hff);
      wr(sgp_pkg::ADDR_P8_DIR, 8'hff);
      rd(sgp_pkg::ADDR_P7_DATA, 8'h00);
      rd(sgp_pkg::ADDR_P8_DATA, 8'h00);
      wr(sgp_pkg::ADDR_P7_DIR, 8'h00);
      wr(sgp_pkg::ADDR_P8_DIR, 8'h00);
      $display("test reset done");
      gpio_case(1'b0);
      gpio_case(1'b1);
      for (int v = 0; v < 16; v++) begin
         wr(sgp_pkg::ADDR_LCD_CTL, 8'(v));
         settle();
         check(n7, (v[3:2] == 2'h0) ? 8'hf0 : 8'h00);
         check(o7 & ~n7, (v[3:2] == 2'h0) ? 8'h0c : 8'h5a);
         check(n8, (v[3:1] == 3'h0) ? 8'hf0 : 8'h00);
         check(o8 & ~n8, (v[3:1] == 3'h0) ? 8'h0c : 8'hc3);
      end
      wr(sgp_pkg::ADDR_LCD_CTL, 8'h00);
      $display("test segment select done");
      for (int i = 0; i < 4; i++) begin
         wr(sgp_pkg::ADDR_P6_DIR, pt[i][0]);
         wr(sgp_pkg::ADDR_P6_PULLUP, pt[i][1]);
         settle();
         check(pu6, pt[i][2]);
         rd(sgp_pkg::ADDR_P6_PULLUP, pt[i][1]);
      end
      $display("test pull-up done");
      for (int i = 0; i < 3; i++) begin
         @(posedge clk_sys);
         pwr_mode <= ms[i];
         wr(sgp_pkg::ADDR_P7_DATA, 8'hff);
         wr(sgp_pkg::ADDR_P7_DIR, 8'hff);
         wr(sgp_pkg::ADDR_P8_DIR, 8'hff);
         settle();
         check(n7 & n8, 8'hf0);
         check(o7 & 8'h0f, 8'h0c);
      end
      @(posedge clk_sys);
      pwr_mode <= sgp_pkg::PWR_STANDBY;
      settle();
      check(n7 & n8, 8'hff);
      @(posedge clk_sys);
      pwr_mode <= sgp_pkg::PWR_SUBACTIVE;
      settle();
      check(n7, 8'h00);
      check(o7, 8'hff);
      $display("test power modes done");
      give_verdict();
   end
endmodule
